/* File: test/dmr_link_model.sv */
// partner model: sink detect levels and snooped aux writes
`default_nettype none
module dmr_link_model (
   input wire logic aclk,
   output logic hpd,
   output logic cad,
   output logic sv,
   output logic [19:0] sa,
   output logic [7:0] sd
);
   timeunit 1ns;
   timeprecision 1ps;
   initial {hpd, cad, sv, sa, sd} = '0;
   task automatic lvl(input logic h, input logic c);
      @(posedge aclk);
      {hpd, cad} <= {h, c};
   endtask : lvl
   task automatic wr(input logic [19:0] a, input logic [7:0] d);
      @(posedge aclk);
      {sv, sa, sd} <= {1'b1, a, d};
      @(posedge aclk);
      {sv, sa, sd} <= {1'b0, ~a, ~d};
   endtask : wr
endmodule : dmr_link_model
`default_nettype wire

/* File: test/tb.sv */
// testbench: mode sequencing, detect pass-through and register access
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import dmr_pkg::*;
   localparam int TO = 16;
   int checks, num_errors, cyc;
   logic aclk, aresetn, lpn, hinv, cinv, hpd, cad, sv, hts, cts, ien, pd, tm, al, irq, oe;
   logic awv, awy, wv, wy, bv, by, arv, ary, rv, ry;
   logic [1:0] sw, pe, eq, bq, rq;
   logic [3:0] oen;
   logic [7:0] awa, ara, sd;
   logic [19:0] sa;
   logic [31:0] wd, rd, s;
   dmr_link_model i_link (.aclk(aclk), .hpd(hpd), .cad(cad), .sv(sv), .sa(sa), .sd(sd));
   dmr_mode_ctrl #(.HPD_TIMEOUT_CYC(TO)) i_dut (.aclk(aclk), .aresetn(aresetn), .ce(1'b1), .low_power_n(lpn),
      .hotplug_from_sink(hpd), .hotplug_invert_sel(hinv), .adapter_detect_from_sink(cad),
      .adapter_invert_sel(cinv), .hotplug_to_source(hts), .adapter_detect_to_source(cts), .adapter_detect_oe(oe),
      .main_link_out_en(oen), .main_link_in_en(ien), .main_link_pulldown(pd), .swing_lvl(sw), .preemph_lvl(pe),
      .eq_lvl(eq), .tmds_mode(tm), .aux_listen_en(al), .sink_irq(irq), .aux_snoop_valid(sv), .aux_snoop_addr(sa),
      .aux_snoop_data(sd), .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awy), .s_axi_wdata(wd),
      .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wy), .s_axi_bresp(bq), .s_axi_bvalid(bv),
      .s_axi_bready(by), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(ary), .s_axi_rdata(rd),
      .s_axi_rresp(rq), .s_axi_rvalid(rv), .s_axi_rready(ry));
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e)
      begin
         num_errors++;
         $display("[ERR] %s exp %h got %h", n, e, g);
      end
   endtask : chk
   task automatic cy(input int n);
      repeat (n) @(posedge aclk);
   endtask : cy
   task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
      @(posedge aclk);
      {awa, wd, awv, wv, by} <= {a, d, 3'h7};
      do
      begin
         @(posedge aclk);
         if (awy) awv <= 1'b0;
         if (wy) wv <= 1'b0;
      end
      while (bv !== 1'b1);
      by <= 1'b0;
      chk("bresp", e, bq);
   endtask : axw
   task automatic axr(input logic [7:0] a, input logic [1:0] e);
      @(posedge aclk);
      {ara, arv, ry} <= {a, 2'h3};
      do
      begin
         @(posedge aclk);
         if (ary) arv <= 1'b0;
      end
      while (rv !== 1'b1);
      ry <= 1'b0;
      s = rd;
      chk("rresp", e, rq);
   endtask : axr
   task automatic md(input logic [1:0] m);
      axr(DMR_OFF_STAT, DMR_RESP_OKAY);
      chk("mode", m, s[1:0]);
   endtask : md
   task automatic t_shut();
      {hinv, cinv} <= 2'h3;
      cy(3);
      chk("hotplug_to_source", 1, hts);
      chk("adapter_detect_to_source", 1, cts);
      chk("pulldown", 1, pd);
      chk("listen", 0, al);
      chk("cad_oe", 0, oe);
      md(DMR_SHUT);
      {hinv, cinv} <= 2'h0;
      cy(3);
      chk("pass", 0, {hts, cts});
      $display("t_shut done");
   endtask : t_shut
   task automatic t_up();
      lpn <= 1'b1;
      cy(2);
      md(DMR_STBY);
      chk("listen_in", 2, {al, ien});
      chk("cad_oe", 1, oe);
      i_link.lvl(1, 0);
      cy(2);
      md(DMR_ACT);
      chk("out_en", 0, oen);
      i_link.wr(DMR_DPCD_LANE_CNT, 8'h02);
      i_link.wr(DMR_DPCD_LANE_SET, 8'h09);
      cy(2);
      chk("out_en", DMR_MASK_2, oen);
      chk("levels", 6'h15, {sw, pe, eq});
      i_link.wr(DMR_DPCD_LANE_CNT, 8'h03);
      cy(2);
      chk("out_en", 0, oen);
      i_link.wr(DMR_DPCD_LANE_SET, 8'h1B);
      i_link.wr(DMR_DPCD_LANE_CNT, 8'h04);
      cy(2);
      chk("out_en", 0, oen);
      i_link.wr(DMR_DPCD_LANE_SET, 8'h09);
      cy(2);
      chk("out_en", DMR_MASK_4, oen);
      $display("t_up done");
   endtask : t_up
   task automatic t_d3();
      i_link.wr(DMR_DPCD_POWER, DMR_PWR_D3);
      cy(2);
      chk("d3_links", 0, {oen, ien});
      md(DMR_D3);
      i_link.wr(DMR_DPCD_POWER, DMR_PWR_D0);
      cy(2);
      md(DMR_ACT);
      chk("out_en", DMR_MASK_4, oen);
      i_link.lvl(1, 1);
      cy(2);
      chk("tmds", 1, tm);
      chk("swing", DMR_TMDS_SWING, sw);
      i_link.wr(DMR_DPCD_LANE_CNT, 8'h01);
      i_link.lvl(1, 0);
      cy(2);
      chk("dp", 5'h0F, {tm, oen});
      $display("t_d3 done");
   endtask : t_d3
   task automatic t_regs();
      axw(DMR_OFF_CTRL, 32'h1, DMR_RESP_OKAY);
      chk("hold", 0, oen);
      axr(DMR_OFF_CTRL, DMR_RESP_OKAY);
      chk("ctrl", 1, s);
      axw(DMR_OFF_STAT, 32'h0, DMR_RESP_SLVERR);
      axr(8'h08, DMR_RESP_SLVERR);
      chk("unmapped", 0, s);
      axw(DMR_OFF_CTRL, 32'h0, DMR_RESP_OKAY);
      chk("release", DMR_MASK_4, oen);
      $display("t_regs done");
   endtask : t_regs
   task automatic t_hpd();
      logic seen;
      seen = 1'b0;
      i_link.lvl(0, 0);
      cy(TO - 4);
      i_link.lvl(1, 0);
      repeat (4)
      begin
         @(posedge aclk);
         seen |= irq;
      end
      chk("irq", 1, seen);
      md(DMR_ACT);
      i_link.lvl(0, 0);
      cy(TO + 4);
      md(DMR_STBY);
      i_link.lvl(1, 0);
      cy(2);
      i_link.wr(DMR_DPCD_POWER, DMR_PWR_D3);
      i_link.lvl(0, 0);
      cy(TO + 4);
      md(DMR_STBY);
      lpn <= 1'b0;
      cy(2);
      md(DMR_SHUT);
      lpn <= 1'b1;
      i_link.lvl(1, 0);
      cy(3);
      chk("out_en", 0, oen);
      $display("t_hpd done");
   endtask : t_hpd
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : tally_and_finish
   initial
   begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end
   always @(posedge aclk)
   begin
      cyc++;
      if (cyc == 5000)
      begin
         num_errors++;
         tally_and_finish();
      end
   end
   initial
   begin
      {aresetn, lpn, hinv, cinv, awv, wv, by, arv, ry, awa, ara, wd} = '0;
      cy(2);
      aresetn <= 1'b1;
      t_shut();
      t_up();
      t_d3();
      t_regs();
      t_hpd();
      tally_and_finish();
   end
endmodule : tb
`default_nettype wire

/* File: verilog/dmr_cfg_if.sv */
// interface: local configuration copy handed to the mode controller
`default_nettype none
interface dmr_cfg_if;
   logic [4:0] lane_cnt;
   logic [7:0] lane_set;
   logic cfg_bad;
   logic trained;
   logic d3_enter;
   logic d3_exit;
   modport shadow (output lane_cnt, lane_set, cfg_bad, trained, d3_enter, d3_exit);
   modport ctrl (input lane_cnt, lane_set, cfg_bad, trained, d3_enter, d3_exit);
endinterface : dmr_cfg_if
`default_nettype wire

/* File: verilog/dmr_dpcd_shadow.sv */
// module: local copy of snooped link configuration writes
`default_nettype none
module dmr_dpcd_shadow (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   input wire logic clear,
   input wire logic wr_en,
   input wire logic [19:0] wr_addr,
   input wire logic [7:0] wr_data,
   dmr_cfg_if.shadow cfg
);
   import dmr_pkg::*;
   logic [4:0] lane_cnt_r;
   logic [7:0] lane_set_r;
   logic bad_cnt_r;
   logic bad_set_r;
   logic wr_cnt;
   logic wr_set;

   function automatic logic cnt_ok(input logic [4:0] c);
      cnt_ok = (c == DMR_CNT_1) || (c == DMR_CNT_2) || (c == DMR_CNT_4);
   endfunction : cnt_ok

   function automatic logic set_ok(input logic [7:0] s);
      set_ok = ({1'b0, s[DMR_SET_SWING_LSB +: 2]} + {1'b0, s[DMR_SET_PRE_LSB +: 2]}) <= DMR_LVL_SUM_MAX;
   endfunction : set_ok

   assign wr_cnt = ce && wr_en && (wr_addr == DMR_DPCD_LANE_CNT);
   assign wr_set = ce && wr_en && (wr_addr == DMR_DPCD_LANE_SET);

   always_ff @(posedge aclk)
   begin
      if (!aresetn || (ce && clear))
      begin
         lane_cnt_r <= DMR_LANE_CNT_RST;
         bad_cnt_r <= 1'b0;
      end
      else if (wr_cnt)
      begin
         lane_cnt_r <= wr_data[4:0];
         bad_cnt_r <= !cnt_ok(wr_data[4:0]);
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn || (ce && clear))
      begin
         lane_set_r <= DMR_LANE_SET_RST;
         bad_set_r <= 1'b0;
      end
      else if (wr_set)
      begin
         lane_set_r <= wr_data;
         bad_set_r <= !set_ok(wr_data);
      end
   end

   assign cfg.lane_cnt = lane_cnt_r;
   assign cfg.lane_set = lane_set_r;
   assign cfg.cfg_bad = bad_cnt_r || bad_set_r;
   // trained once a valid count is held
   assign cfg.trained = cnt_ok(lane_cnt_r) && !bad_cnt_r;
   assign cfg.d3_enter = ce && wr_en && !clear && (wr_addr == DMR_DPCD_POWER) && (wr_data == DMR_PWR_D3);
   assign cfg.d3_exit = ce && wr_en && !clear && (wr_addr == DMR_DPCD_POWER) && (wr_data == DMR_PWR_D0);

   AST_SHADOW_WR: assert property (@(posedge aclk) disable iff (!aresetn)
      wr_cnt && !clear |=> lane_cnt_r == $past(wr_data[4:0]))
      else $error("snooped lane count write not copied");
   AST_BAD_CNT: assert property (@(posedge aclk) disable iff (!aresetn)
      wr_cnt && !clear && !cnt_ok(wr_data[4:0]) |=> cfg.cfg_bad)
      else $error("invalid lane count not flagged");
endmodule : dmr_dpcd_shadow
`default_nettype wire

/* File: verilog/dmr_hpd_timer.sv */
// module: sink hot plug low-duration timer and interrupt pulse detector
`default_nettype none
module dmr_hpd_timer #(
   parameter int TIMEOUT_CYC = dmr_pkg::DMR_HPD_TIMEOUT_DEF
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   input wire logic hpd,
   output logic lost,
   output logic irq,
   output logic rise
);
   import dmr_pkg::*;
   localparam logic [DMR_HPD_CNT_W-1:0] TO_W = DMR_HPD_CNT_W'(TIMEOUT_CYC);
   logic [DMR_HPD_CNT_W-1:0] low_cnt_r;
   logic hpd_d_r;
   logic irq_r;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         low_cnt_r <= '0;
      else if (ce)
      begin
         if (hpd)
            low_cnt_r <= '0;
         else if (low_cnt_r != TO_W)
            low_cnt_r <= low_cnt_r + 1'b1;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         hpd_d_r <= 1'b0;
      else if (ce)
         hpd_d_r <= hpd;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         irq_r <= 1'b0;
      else if (ce)
         irq_r <= hpd && (low_cnt_r != '0) && (low_cnt_r != TO_W);
   end

   assign lost = (low_cnt_r == TO_W);
   assign irq = irq_r;
   assign rise = ce && hpd && !hpd_d_r;

   AST_IRQ_SHORT: assert property (@(posedge aclk) disable iff (!aresetn)
      ce && hpd && !lost && (low_cnt_r != '0) |=> irq)
      else $error("short hot plug low gave no interrupt");
   AST_LOST_LOW: assert property (@(posedge aclk) disable iff (!aresetn)
      lost && $past(ce) |-> !$past(hpd) && (low_cnt_r == TO_W))
      else $error("hot plug loss without a full low period");
endmodule : dmr_hpd_timer
`default_nettype wire

/* File: verilog/dmr_mode_ctrl.sv */
// module: repeater mode sequencer, detect pass-through and register slave
// Function
// - Low-power input low: shutdown, main outputs off and grounded, inputs ignored.
// - In shutdown the source hot plug output follows sink hot plug; rest idle.
// - Shutdown holds local configuration copies reset to defaults.
// - Adapter detect to source is sink adapter detect, inverted when selected.
// - Hot plug to source is sink hot plug, inverted when selected.
// - Low-power input rising moves shutdown to standby and starts AUX listening.
// - Standby: main link off, AUX monitoring on.
// - Standby to active when sink hot plug goes high.
// - Active to standby when hot plug stays low past the timeout.
// - Short hot plug low keeps active mode and counts as sink interrupt.
// - Snooped D3 entry while active disables main link, AUX stays on.
// - D3 to active on D3 exit command or hot plug rising.
// - D3 to standby when hot plug stays low past the timeout.
// - Active mode is TMDS when sink adapter detect high, else DP.
// - TMDS mode uses fixed swing and ignores AUX traffic.
// - DP mode takes swing, equalization, lane count from observed training.
// - Four swing and four pre-emphasis levels chosen from training.
// - In DP mode main outputs stay off until training writes enabling values; TMDS mode enables all four lanes.
// - Every snooped configuration write outside shutdown, while sink adapter detect is low, updates the local copy.
// - Invalid lane count or lane setting write forces output disable.
// - Output disable ends once all local copies hold valid entries.
// - Low-power input low from active or standby enters shutdown.
// - Exit from D3 or standby to active within the maximum exit time.
`default_nettype none
module dmr_mode_ctrl #(
   parameter int HPD_TIMEOUT_CYC = dmr_pkg::DMR_HPD_TIMEOUT_DEF
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   input wire logic low_power_n,
   input wire logic hotplug_from_sink,
   input wire logic hotplug_invert_sel,
   input wire logic adapter_detect_from_sink,
   input wire logic adapter_invert_sel,
   output logic hotplug_to_source,
   output logic adapter_detect_to_source,
   output logic adapter_detect_oe,
   output logic [3:0] main_link_out_en,
   output logic main_link_in_en,
   output logic main_link_pulldown,
   output logic [1:0] swing_lvl,
   output logic [1:0] preemph_lvl,
   output logic [1:0] eq_lvl,
   output logic tmds_mode,
   output logic aux_listen_en,
   output logic sink_irq,
   input wire logic aux_snoop_valid,
   input wire logic [19:0] aux_snoop_addr,
   input wire logic [7:0] aux_snoop_data,
   input wire logic [dmr_pkg::DMR_AXI_AW-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [dmr_pkg::DMR_AXI_AW-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   import dmr_pkg::*;

   dmr_mode_e mode_r;
   dmr_mode_e mode_nxt;
   logic hotplug_to_source_r;
   logic adapter_detect_to_source_r;
   logic [1:0] swing_r;
   logic [1:0] pre_r;
   logic [1:0] eq_r;
   logic [31:0] ctrl_r;
   logic hpd_lost;
   logic hpd_irq;
   logic hpd_rise;
   logic in_shut;
   logic is_tmds;
   logic link_on;
   logic [3:0] lane_mask;
   logic [DMR_AXI_AW-1:0] awaddr_r;
   logic aw_held_r;
   logic [31:0] wdata_r;
   logic [3:0] wstrb_r;
   logic w_held_r;
   logic bvalid_r;
   logic [1:0] bresp_r;
   logic rvalid_r;
   logic [1:0] rresp_r;
   logic [31:0] rdata_r;
   logic [31:0] stat;
   logic wr_go;

   dmr_cfg_if cfg ();

   assign in_shut = (mode_r == DMR_SHUT);
   assign is_tmds = adapter_detect_from_sink;

   dmr_hpd_timer #(
      .TIMEOUT_CYC(HPD_TIMEOUT_CYC)
   ) u_timer (
      .aclk(aclk),
      .aresetn(aresetn),
      .ce(ce),
      .hpd(hotplug_from_sink),
      .lost(hpd_lost),
      .irq(hpd_irq),
      .rise(hpd_rise)
   );

   dmr_dpcd_shadow u_shadow (
      .aclk(aclk),
      .aresetn(aresetn),
      .ce(ce),
      .clear(!low_power_n),
      .wr_en(aux_snoop_valid && !in_shut && !is_tmds),
      .wr_addr(aux_snoop_addr),
      .wr_data(aux_snoop_data),
      .cfg(cfg)
   );

   // mode sequencing
   always_comb
   begin
      mode_nxt = mode_r;
      unique case (mode_r)
         DMR_SHUT:
            if (low_power_n)
               mode_nxt = DMR_STBY;
         DMR_STBY:
            if (hotplug_from_sink)
               mode_nxt = DMR_ACT;
         DMR_ACT:
            if (hpd_lost)
               mode_nxt = DMR_STBY;
            else if (cfg.d3_enter)
               mode_nxt = DMR_D3;
         DMR_D3:
            if (hpd_lost)
               mode_nxt = DMR_STBY;
            else if (cfg.d3_exit || hpd_rise)
               mode_nxt = DMR_ACT;
      endcase
      if (!low_power_n)
         mode_nxt = DMR_SHUT;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         mode_r <= DMR_SHUT;
      else if (ce)
         mode_r <= mode_nxt;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         hotplug_to_source_r <= 1'b0;
      else if (ce)
         hotplug_to_source_r <= hotplug_from_sink ^ hotplug_invert_sel;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         adapter_detect_to_source_r <= 1'b0;
      else if (ce)
         adapter_detect_to_source_r <= adapter_detect_from_sink ^ adapter_invert_sel;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         swing_r <= 2'h0;
         pre_r <= 2'h0;
         eq_r <= 2'h0;
      end
      else if (ce)
      begin
         if (is_tmds)
         begin
            swing_r <= DMR_TMDS_SWING;
            pre_r <= 2'h0;
            eq_r <= 2'h0;
         end
         else
         begin
            swing_r <= cfg.lane_set[DMR_SET_SWING_LSB +: 2];
            pre_r <= cfg.lane_set[DMR_SET_PRE_LSB +: 2];
            eq_r <= cfg.lane_set[DMR_SET_PRE_LSB +: 2];
         end
      end
   end

   always_comb
   begin
      unique case (cfg.lane_cnt)
         DMR_CNT_1: lane_mask = DMR_MASK_1;
         DMR_CNT_2: lane_mask = DMR_MASK_2;
         DMR_CNT_4: lane_mask = DMR_MASK_4;
         default: lane_mask = DMR_MASK_NONE;
      endcase
   end

   assign link_on = (mode_r == DMR_ACT) && !cfg.cfg_bad && !ctrl_r[DMR_CTRL_HOLD_BIT];
   assign main_link_out_en = !link_on ? DMR_MASK_NONE : (is_tmds ? DMR_MASK_4 : lane_mask);
   assign main_link_in_en = (mode_r == DMR_ACT);
   assign main_link_pulldown = in_shut;
   assign aux_listen_en = !in_shut;
   assign tmds_mode = (mode_r == DMR_ACT) && is_tmds;
   assign hotplug_to_source = hotplug_to_source_r;
   assign adapter_detect_to_source = adapter_detect_to_source_r;
   assign adapter_detect_oe = !in_shut;
   assign swing_lvl = swing_r;
   assign preemph_lvl = pre_r;
   assign eq_lvl = eq_r;
   assign sink_irq = hpd_irq && (mode_r == DMR_ACT);

   // register bus write path
   assign s_axi_awready = !aw_held_r;
   assign s_axi_wready = !w_held_r;
   assign wr_go = aw_held_r && w_held_r && !bvalid_r;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_held_r <= 1'b0;
         awaddr_r <= '0;
      end
      else if (ce)
      begin
         if (s_axi_awvalid && !aw_held_r)
         begin
            aw_held_r <= 1'b1;
            awaddr_r <= s_axi_awaddr;
         end
         else if (wr_go)
            aw_held_r <= 1'b0;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         w_held_r <= 1'b0;
         wdata_r <= '0;
         wstrb_r <= '0;
      end
      else if (ce)
      begin
         if (s_axi_wvalid && !w_held_r)
         begin
            w_held_r <= 1'b1;
            wdata_r <= s_axi_wdata;
            wstrb_r <= s_axi_wstrb;
         end
         else if (wr_go)
            w_held_r <= 1'b0;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         ctrl_r <= DMR_CTRL_RST;
      else if (ce && wr_go && (awaddr_r == DMR_OFF_CTRL))
      begin
         for (int i = 0; i < 4; i++)
            if (wstrb_r[i])
               ctrl_r[i*8 +: 8] <= wdata_r[i*8 +: 8];
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         bvalid_r <= 1'b0;
         bresp_r <= DMR_RESP_OKAY;
      end
      else if (ce)
      begin
         if (wr_go)
         begin
            bvalid_r <= 1'b1;
            bresp_r <= (awaddr_r == DMR_OFF_CTRL) ? DMR_RESP_OKAY : DMR_RESP_SLVERR;
         end
         else if (s_axi_bready)
            bvalid_r <= 1'b0;
      end
   end

   assign s_axi_bvalid = bvalid_r;
   assign s_axi_bresp = bresp_r;

   // status word
   always_comb
   begin
      stat = '0;
      stat[DMR_ST_MODE_LSB +: 2] = mode_r;
      stat[DMR_ST_OUTDIS_BIT] = cfg.cfg_bad;
      stat[DMR_ST_TMDS_BIT] = tmds_mode;
      stat[DMR_ST_TRAINED_BIT] = cfg.trained;
      stat[DMR_ST_HPD_BIT] = hotplug_from_sink;
      stat[DMR_ST_LANES_LSB +: 4] = main_link_out_en;
      stat[DMR_ST_SWING_LSB +: 2] = swing_r;
      stat[DMR_ST_PRE_LSB +: 2] = pre_r;
      stat[DMR_ST_EQ_LSB +: 2] = eq_r;
   end

   // register bus read path
   assign s_axi_arready = !rvalid_r;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         rvalid_r <= 1'b0;
         rdata_r <= '0;
         rresp_r <= DMR_RESP_OKAY;
      end
      else if (ce)
      begin
         if (s_axi_arvalid && !rvalid_r)
         begin
            rvalid_r <= 1'b1;
            rresp_r <= DMR_RESP_OKAY;
            if (s_axi_araddr == DMR_OFF_CTRL)
               rdata_r <= ctrl_r;
            else if (s_axi_araddr == DMR_OFF_STAT)
               rdata_r <= stat;
            else
            begin
               rdata_r <= '0;
               rresp_r <= DMR_RESP_SLVERR;
            end
         end
         else if (s_axi_rready)
            rvalid_r <= 1'b0;
      end
   end

   assign s_axi_rvalid = rvalid_r;
   assign s_axi_rdata = rdata_r;
   assign s_axi_rresp = rresp_r;

   localparam int AST_EXIT_MAX = DMR_EXIT_CYC;

   AST_SHUT_LINK: assert property (@(posedge aclk) disable iff (!aresetn)
      ce && !low_power_n |=> in_shut && main_link_pulldown && (main_link_out_en == 4'h0) && !main_link_in_en)
      else $error("low-power low did not shut the main link");
   AST_SHUT_IO: assert property (@(posedge aclk) disable iff (!aresetn)
      in_shut |-> !adapter_detect_oe && !aux_listen_en && !sink_irq)
      else $error("outputs active in shutdown");
   AST_HPD_PASS: assert property (@(posedge aclk) disable iff (!aresetn)
      ce |=> hotplug_to_source == ($past(hotplug_from_sink) ^ $past(hotplug_invert_sel)))
      else $error("hot plug to source wrong polarity");
   AST_CAD_PASS: assert property (@(posedge aclk) disable iff (!aresetn)
      ce |=> adapter_detect_to_source == ($past(adapter_detect_from_sink) ^ $past(adapter_invert_sel)))
      else $error("adapter detect to source wrong polarity");
   AST_SHADOW_CLR: assert property (@(posedge aclk) disable iff (!aresetn)
      ce && !low_power_n |=> (cfg.lane_cnt == DMR_LANE_CNT_RST) && (cfg.lane_set == DMR_LANE_SET_RST))
      else $error("local copies not reset in shutdown");
   AST_WAKE: assert property (@(posedge aclk) disable iff (!aresetn)
      ce && in_shut && low_power_n |=> (mode_r == DMR_STBY) && aux_listen_en && (main_link_out_en == 4'h0))
      else $error("no standby after low-power release");
   AST_STBY_ACT: assert property (@(posedge aclk) disable iff (!aresetn)
      ce && (mode_r == DMR_STBY) && low_power_n && hotplug_from_sink |=> mode_r == DMR_ACT)
      else $error("standby ignored hot plug");
   AST_LOST: assert property (@(posedge aclk) disable iff (!aresetn)
      ce && low_power_n && hpd_lost && ((mode_r == DMR_ACT) || (mode_r == DMR_D3)) |=> mode_r == DMR_STBY)
      else $error("hot plug loss did not return to standby");
   AST_D3_IN: assert property (@(posedge aclk) disable iff (!aresetn)
      (mode_r == DMR_ACT) && low_power_n && !hpd_lost && cfg.d3_enter |=> (mode_r == DMR_D3) && !main_link_in_en)
      else $error("D3 entry not taken");
   AST_D3_OUT: assert property (@(posedge aclk) disable iff (!aresetn)
      (mode_r == DMR_D3) && low_power_n && !hpd_lost && (cfg.d3_exit || hpd_rise) |=> mode_r == DMR_ACT)
      else $error("D3 exit not taken");
   AST_OUTDIS: assert property (@(posedge aclk) disable iff (!aresetn)
      cfg.cfg_bad |-> main_link_out_en == 4'h0)
      else $error("outputs on with an invalid entry");
   AST_TMDS: assert property (@(posedge aclk) disable iff (!aresetn)
      ce && is_tmds |=> swing_lvl == DMR_TMDS_SWING)
      else $error("TMDS swing not fixed");
   AST_EXIT_TIME: assert property (@(posedge aclk) disable iff (!aresetn)
      (mode_r == DMR_STBY) && ce && low_power_n && hotplug_from_sink |-> ##[1:AST_EXIT_MAX] (mode_r == DMR_ACT))
      else $error("exit to active too slow");
   COV_ACTIVE_DP: cover property (@(posedge aclk) disable iff (!aresetn)
      (mode_r == DMR_ACT) && !is_tmds && (main_link_out_en == DMR_MASK_4));
   COV_D3_RETURN: cover property (@(posedge aclk) disable iff (!aresetn)
      (mode_r == DMR_D3) ##1 (mode_r == DMR_ACT));
   COV_SINK_IRQ: cover property (@(posedge aclk) disable iff (!aresetn) sink_irq);
   COV_OUTDIS: cover property (@(posedge aclk) disable iff (!aresetn) (mode_r == DMR_ACT) && cfg.cfg_bad);
endmodule : dmr_mode_ctrl
`default_nettype wire

/* File: verilog/dmr_pkg.sv */
// package: constants and types for the repeater mode controller
`default_nettype none
package dmr_pkg;
   // register bus
   localparam int DMR_AXI_AW = 8;
   localparam logic [7:0] DMR_OFF_CTRL = 8'h00;
   localparam logic [7:0] DMR_OFF_STAT = 8'h04;
   localparam logic [1:0] DMR_RESP_OKAY = 2'h0;
   localparam logic [1:0] DMR_RESP_SLVERR = 2'h2;
   localparam logic [31:0] DMR_CTRL_RST = 32'h0000_0000;
   localparam int DMR_CTRL_HOLD_BIT = 0;
   // status field positions
   localparam int DMR_ST_MODE_LSB = 0;
   localparam int DMR_ST_OUTDIS_BIT = 2;
   localparam int DMR_ST_TMDS_BIT = 3;
   localparam int DMR_ST_TRAINED_BIT = 4;
   localparam int DMR_ST_HPD_BIT = 5;
   localparam int DMR_ST_LANES_LSB = 8;
   localparam int DMR_ST_SWING_LSB = 12;
   localparam int DMR_ST_PRE_LSB = 14;
   localparam int DMR_ST_EQ_LSB = 16;
   // snooped link configuration registers
   localparam logic [19:0] DMR_DPCD_LANE_CNT = 20'h0_0101;
   localparam logic [19:0] DMR_DPCD_LANE_SET = 20'h0_0103;
   localparam logic [19:0] DMR_DPCD_POWER = 20'h0_0600;
   localparam logic [7:0] DMR_PWR_D0 = 8'h01;
   localparam logic [7:0] DMR_PWR_D3 = 8'h02;
   localparam logic [4:0] DMR_LANE_CNT_RST = 5'h00;
   localparam logic [7:0] DMR_LANE_SET_RST = 8'h00;
   localparam logic [4:0] DMR_CNT_1 = 5'h01;
   localparam logic [4:0] DMR_CNT_2 = 5'h02;
   localparam logic [4:0] DMR_CNT_4 = 5'h04;
   localparam logic [3:0] DMR_MASK_NONE = 4'h0;
   localparam logic [3:0] DMR_MASK_1 = 4'h1;
   localparam logic [3:0] DMR_MASK_2 = 4'h3;
   localparam logic [3:0] DMR_MASK_4 = 4'hF;
   localparam int DMR_SET_SWING_LSB = 0;
   localparam int DMR_SET_PRE_LSB = 3;
   localparam logic [2:0] DMR_LVL_SUM_MAX = 3'h3;
   localparam logic [1:0] DMR_TMDS_SWING = 2'h1;
   // timing
   localparam int DMR_CLK_PERIOD_NS = 10;
   localparam int DMR_EXIT_MAX_NS = 1800;
   localparam int DMR_EXIT_CYC = (DMR_EXIT_MAX_NS / DMR_CLK_PERIOD_NS < 1) ? 1 :
      DMR_EXIT_MAX_NS / DMR_CLK_PERIOD_NS;
   localparam int DMR_HPD_TIMEOUT_DEF = 200000;
   localparam int DMR_HPD_CNT_W = 24;
   typedef enum logic [1:0] {DMR_SHUT, DMR_STBY, DMR_ACT, DMR_D3} dmr_mode_e;
endpackage : dmr_pkg
`default_nettype wire
